// >>> rtl/hlier_pkg.sv
package hlier_pkg;

  // Register offsets
  localparam logic [7:0] HOST_CTRL_SET_OFS = 8'h50;
  localparam logic [7:0] HOST_CTRL_CLR_OFS = 8'h54;
  localparam logic [7:0] EVT_SET_OFS = 8'h80;
  localparam logic [7:0] EVT_CLR_OFS = 8'h84;
  localparam logic [7:0] MASK_SET_OFS = 8'h88;
  localparam logic [7:0] MASK_CLR_OFS = 8'h8C;
  localparam logic [7:0] LINK_CTRL_SET_OFS = 8'hE0;
  localparam logic [7:0] LINK_CTRL_CLR_OFS = 8'hE4;
  localparam logic [7:0] LINE_CTRL_OFS = 8'hEC;

  // Event word bit positions
  localparam int LATE_ACK_BIT = 27;
  localparam int BYTE_ARRIVED_BIT = 26;
  localparam int OVERLONG_BIT = 25;
  localparam int FATAL_HALT_BIT = 24;
  localparam int MISMATCH_BIT = 23;
  localparam int BUS_REINIT_BIT = 17;
  localparam int CENSUS_DONE_BIT = 16;
  localparam int CENSUS_DONE2_BIT = 15;
  localparam int RX_SUMMARY_BIT = 7;
  localparam int TX_SUMMARY_BIT = 6;

  // Control field positions
  localparam int LATE_ACK_EN_BIT = 29;
  localparam int TIMING_ROOT_BIT = 21;
  localparam int LINE_BYTE_LSB = 16;

  // Implemented latched bits, and bits fed by the generic source port
  localparam logic [31:0] EVT_IMPL_MASK = 32'h6FFF_833F;
  localparam logic [31:0] EVT_HW_SRC_MASK = 32'h007F_033F;
  localparam logic [31:0] EVT_RSVD_ZERO = 32'h9000_7C00;

  // Reset values
  localparam logic [31:0] EVT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // Event bits owned by each halting subunit
  localparam int NUM_SUBUNITS = 4;
  localparam logic [31:0] SUBUNIT_EVT_MAP [NUM_SUBUNITS] = '{
    32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008};

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OVERLONG_TIME_US = 125;
  localparam int OVERLONG_CYCLES = (OVERLONG_TIME_US * 1000000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEASURE = 2'b10
  } hlier_meas_type;

endpackage

// >>> rtl/hlier_top.sv
// How it works
// - Edge or set-port write raises event flag
// - Only clear-port one-writes clear a flag, except bit 16 on bus reinit
// - Event reads return flags ANDed with mask
// - Bits 15-10, 28, 31 reset to zero
// - Bit 31 reads zero, ignores writes
// - Bit 29 is software-only event
// - Bit 28 reads zero, ignores writes
// - Late-ack conditions set bit 27 when enabled
// - Line byte arrival sets 26, byte readable
// - Overlong period as timing root sets 25
// - Overlong event clears timing root enable
// - Subunit halting error sets bit 24
// - Fatal halt blocks offending contexts' events
// - Received timer mismatch sets bit 23
// - Bits 14-10 always read zero
// - Bits 7, 6 are live masked ORs
// - Bus reinit set clears census done
module hlier_top #(
  parameter int OVERLONG_LIMIT = hlier_pkg::OVERLONG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_timing_root_enable,
  output logic o_late_ack_report_enable,
  input wire logic [31:0] i_evt_src,
  input wire logic i_rx_data_waiting,
  input wire logic i_phys_resp_busy,
  input wire logic i_tardy_ack_sent,
  input wire logic i_line_layer_byte_arrived,
  input wire logic [7:0] i_line_layer_byte,
  input wire logic i_cs_tx_start,
  input wire logic i_subaction_gap_end,
  input wire logic [3:0] i_subunit_halt,
  input wire logic i_rx_cs_valid,
  input wire logic [6:0] i_rx_seconds_field,
  input wire logic [12:0] i_rx_period_count_field,
  input wire logic [6:0] i_seconds_field,
  input wire logic [12:0] i_period_count_field,
  input wire logic [7:0] i_rx_ctx_events,
  input wire logic [7:0] i_rx_ctx_mask,
  input wire logic [7:0] i_tx_ctx_events,
  input wire logic [7:0] i_tx_ctx_mask
);

  logic [31:0] flags_ff;
  logic [31:0] nxt_flags;
  logic [31:0] mask_ff;
  logic [31:0] src_prev_ff;
  logic [31:0] blk_ff;
  logic [1:0] summary_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic late_ack_en_ff;
  logic timing_root_ff;
  logic [7:0] line_byte_ff;
  hlier_pkg::hlier_meas_type meas_ff;
  logic [14:0] meas_cnt_ff;
  logic overlong_pulse;
  logic [31:0] src_lvl;
  logic [31:0] hw_rise;
  logic [31:0] hw_set;
  logic [31:0] sw_set;
  logic [31:0] sw_clr;
  logic [31:0] evt_view;
  logic [31:0] halt_map;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Decoded write strobes
  logic wr_evt_set;
  logic wr_evt_clr;
  assign wr_evt_set = i_wr && hit(i_addr, hlier_pkg::EVT_SET_OFS);
  assign wr_evt_clr = i_wr && hit(i_addr, hlier_pkg::EVT_CLR_OFS);

  // Subunit-to-event map of halting units
  always_comb begin
    halt_map = '0;
    for (int u = 0; u < hlier_pkg::NUM_SUBUNITS; u++) begin
      if (i_subunit_halt[u]) begin
        halt_map = halt_map | hlier_pkg::SUBUNIT_EVT_MAP[u];
      end
    end
  end

  // Source levels gathered into one word
  always_comb begin
    src_lvl = i_evt_src & hlier_pkg::EVT_HW_SRC_MASK;
    src_lvl[hlier_pkg::LATE_ACK_BIT] = late_ack_en_ff &&
        (i_rx_data_waiting || i_phys_resp_busy || i_tardy_ack_sent);
    src_lvl[hlier_pkg::BYTE_ARRIVED_BIT] = i_line_layer_byte_arrived;
    src_lvl[hlier_pkg::OVERLONG_BIT] = overlong_pulse;
    src_lvl[hlier_pkg::FATAL_HALT_BIT] = |i_subunit_halt;
    src_lvl[hlier_pkg::MISMATCH_BIT] = i_rx_cs_valid &&
        ((i_rx_seconds_field != i_seconds_field) ||
         (i_rx_period_count_field != i_period_count_field));
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      src_prev_ff <= '0;
    end else begin
      src_prev_ff <= src_lvl;
    end
  end

  assign hw_rise = src_lvl & ~src_prev_ff;

  always_comb begin
    hw_set = hw_rise;
    if (flags_ff[hlier_pkg::FATAL_HALT_BIT]) begin
      hw_set = hw_set & ~blk_ff;
    end
    if (hw_set[hlier_pkg::CENSUS_DONE_BIT]) begin
      hw_set[hlier_pkg::CENSUS_DONE2_BIT] = 1'b1;
    end
  end

  assign sw_set = wr_evt_set ? i_wdata : '0;
  assign sw_clr = wr_evt_clr ? i_wdata : '0;

  always_comb begin
    nxt_flags = (flags_ff & ~sw_clr) | sw_set | hw_set;
    if (hw_set[hlier_pkg::BUS_REINIT_BIT]) begin
      nxt_flags[hlier_pkg::CENSUS_DONE_BIT] = 1'b0;
    end
    nxt_flags = nxt_flags & hlier_pkg::EVT_IMPL_MASK;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flags_ff <= hlier_pkg::EVT_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Offending contexts held while the fatal flag stands
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      blk_ff <= '0;
    end else if (!nxt_flags[hlier_pkg::FATAL_HALT_BIT]) begin
      blk_ff <= '0;
    end else begin
      blk_ff <= blk_ff | halt_map;
    end
  end

  // Mask register, set and clear ports
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mask_ff <= hlier_pkg::MASK_RESET;
    end else if (i_wr && hit(i_addr, hlier_pkg::MASK_SET_OFS)) begin
      mask_ff <= mask_ff | i_wdata;
    end else if (i_wr && hit(i_addr, hlier_pkg::MASK_CLR_OFS)) begin
      mask_ff <= mask_ff & ~i_wdata;
    end
  end

  // Late ack report enable
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      late_ack_en_ff <= 1'b0;
    end else if (i_wr && hit(i_addr, hlier_pkg::HOST_CTRL_SET_OFS) &&
                 i_wdata[hlier_pkg::LATE_ACK_EN_BIT]) begin
      late_ack_en_ff <= 1'b1;
    end else if (i_wr && hit(i_addr, hlier_pkg::HOST_CTRL_CLR_OFS) &&
                 i_wdata[hlier_pkg::LATE_ACK_EN_BIT]) begin
      late_ack_en_ff <= 1'b0;
    end
  end

  // Timing root enable
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      timing_root_ff <= 1'b0;
    end else if (overlong_pulse) begin
      timing_root_ff <= 1'b0;
    end else if (i_wr && hit(i_addr, hlier_pkg::LINK_CTRL_SET_OFS) &&
                 i_wdata[hlier_pkg::TIMING_ROOT_BIT]) begin
      timing_root_ff <= 1'b1;
    end else if (i_wr && hit(i_addr, hlier_pkg::LINK_CTRL_CLR_OFS) &&
                 i_wdata[hlier_pkg::TIMING_ROOT_BIT]) begin
      timing_root_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meas_ff <= hlier_pkg::ST_IDLE;
      meas_cnt_ff <= '0;
    end else begin
      case (meas_ff)
        hlier_pkg::ST_IDLE: begin
          meas_cnt_ff <= '0;
          if (i_cs_tx_start && timing_root_ff) begin
            meas_ff <= hlier_pkg::ST_MEASURE;
          end
        end
        hlier_pkg::ST_MEASURE: begin
          meas_cnt_ff <= meas_cnt_ff + 15'd1;
          if (i_subaction_gap_end || overlong_pulse || !timing_root_ff) begin
            meas_ff <= hlier_pkg::ST_IDLE;
          end
        end
        default: begin
          meas_ff <= hlier_pkg::ST_IDLE;
          meas_cnt_ff <= '0;
        end
      endcase
    end
  end

  assign overlong_pulse = (meas_ff == hlier_pkg::ST_MEASURE) && !i_subaction_gap_end &&
      (meas_cnt_ff == 15'(OVERLONG_LIMIT));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      line_byte_ff <= '0;
    end else if (i_line_layer_byte_arrived) begin
      line_byte_ff <= i_line_layer_byte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      summary_ff <= '0;
    end else begin
      summary_ff <= {|(i_rx_ctx_events & i_rx_ctx_mask),
                     |(i_tx_ctx_events & i_tx_ctx_mask)};
    end
  end

  always_comb begin
    evt_view = flags_ff;
    evt_view[hlier_pkg::RX_SUMMARY_BIT] = summary_ff[1];
    evt_view[hlier_pkg::TX_SUMMARY_BIT] = summary_ff[0];
    evt_view = evt_view & mask_ff & ~hlier_pkg::EVT_RSVD_ZERO;
  end

  // Register read port
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_rd) begin
      rdata_ff <= '0;
    end else begin
      case (i_addr)
        hlier_pkg::EVT_SET_OFS, hlier_pkg::EVT_CLR_OFS: begin
          rdata_ff <= evt_view;
        end
        hlier_pkg::MASK_SET_OFS, hlier_pkg::MASK_CLR_OFS: begin
          rdata_ff <= mask_ff;
        end
        hlier_pkg::HOST_CTRL_SET_OFS, hlier_pkg::HOST_CTRL_CLR_OFS: begin
          rdata_ff <= 32'(late_ack_en_ff) << hlier_pkg::LATE_ACK_EN_BIT;
        end
        hlier_pkg::LINK_CTRL_SET_OFS, hlier_pkg::LINK_CTRL_CLR_OFS: begin
          rdata_ff <= 32'(timing_root_ff) << hlier_pkg::TIMING_ROOT_BIT;
        end
        hlier_pkg::LINE_CTRL_OFS: begin
          rdata_ff <= 32'(line_byte_ff) << hlier_pkg::LINE_BYTE_LSB;
        end
        default: begin
          rdata_ff <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |evt_view;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_irq = irq_ff;
  assign o_timing_root_enable = timing_root_ff;
  assign o_late_ack_report_enable = late_ack_en_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_set_port_bit29: assert property (
    wr_evt_set && i_wdata[29] |=> flags_ff[29] [*1] ##0 !$past(i_srst))
    else $error("set port write did not raise bit 29");
  a_clear_only_port: assert property (
    ((flags_ff & ~$past(flags_ff) & ~$past(sw_set | hw_set)) == 32'h0000_0000) ##0
    ((~flags_ff & $past(flags_ff) & ~$past(sw_clr) &
      ~(32'(1) << hlier_pkg::CENSUS_DONE_BIT)) == 32'h0000_0000))
    else $error("flag dropped without clear port write");
  a_read_masked: assert property (
    i_rd && i_addr == hlier_pkg::EVT_CLR_OFS |=> o_rdata == $past(evt_view))
    else $error("event read not masked value");
  a_rsvd_zero: assert property (
    (flags_ff & hlier_pkg::EVT_RSVD_ZERO) == 32'h0000_0000 &&
    ((o_rdata & hlier_pkg::EVT_RSVD_ZERO) == 32'h0000_0000 || $past(i_addr[3])))
    else $error("reserved event bit not zero");
  a_late_ack_set: assert property (
    late_ack_en_ff && i_tardy_ack_sent && !src_prev_ff[27] |=> flags_ff[27])
    else $error("late ack event missed");
  a_byte_capture: assert property (
    i_line_layer_byte_arrived && !src_prev_ff[26] |=>
    flags_ff[26] && line_byte_ff == $past(i_line_layer_byte))
    else $error("line byte arrival not recorded");
  a_overlong_clear: assert property (
    overlong_pulse |=> flags_ff[25] && !timing_root_ff)
    else $error("overlong event handling wrong");

  a_halt_block: assert property (
    flags_ff[24] && blk_ff[0] && !flags_ff[0] && !wr_evt_set |=> !flags_ff[0])
    else $error("blocked context event was set");

  a_census_clear: assert property (
    hw_set[17] |=> flags_ff[17] && !flags_ff[16])
    else $error("census flag not cleared on reinit");

  a_irq_follows: assert property (
    ##1 o_irq == $past(|evt_view))
    else $error("interrupt request mismatched");

  a_set_wins: assert property (
    wr_evt_clr && (hw_set & i_wdata & hlier_pkg::EVT_IMPL_MASK) != 0 |=>
    (flags_ff & $past(hw_set & i_wdata & hlier_pkg::EVT_IMPL_MASK)) ==
    $past(hw_set & i_wdata & hlier_pkg::EVT_IMPL_MASK))
    else $error("hardware set lost to clear");

  c_overlong: cover property (overlong_pulse);
  c_set_vs_clear: cover property (wr_evt_clr && (hw_set & i_wdata) != 0);
  c_irq_rise: cover property (!o_irq ##1 o_irq);
  c_halt_blocked: cover property (flags_ff[24] && |blk_ff);

endmodule

// >>> verif/test_host_link_interrupt_event_reg.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t ns: got %h exp %h", $time, (g), (e)); end end

module test_host_link_interrupt_event_reg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ES = hlier_pkg::EVT_SET_OFS;
  localparam logic [7:0] EC = hlier_pkg::EVT_CLR_OFS;
  localparam logic [31:0] ALL = 32'hBFFF_FFFF;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0, i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic o_irq, o_timing_root_enable, o_late_ack_report_enable;
  logic [31:0] i_evt_src = 32'h0000_0000;
  logic i_rx_data_waiting = 1'b0, i_phys_resp_busy = 1'b0, i_tardy_ack_sent = 1'b0;
  logic i_line_layer_byte_arrived = 1'b0;
  logic [7:0] i_line_layer_byte = 8'h00;
  logic i_cs_tx_start = 1'b0, i_subaction_gap_end = 1'b0, i_rx_cs_valid = 1'b0;
  logic [3:0] i_subunit_halt = 4'h0;
  logic [6:0] i_rx_seconds_field = 7'h00, i_seconds_field = 7'h00;
  logic [12:0] i_rx_period_count_field = 13'h0000, i_period_count_field = 13'h0000;
  logic [7:0] i_rx_ctx_events = 8'h00, i_rx_ctx_mask = 8'h00;
  logic [7:0] i_tx_ctx_events = 8'h00, i_tx_ctx_mask = 8'h00;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] d;
  int n;

  hlier_top #(.OVERLONG_LIMIT(20)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_timing_root_enable(o_timing_root_enable),
    .o_late_ack_report_enable(o_late_ack_report_enable), .i_evt_src(i_evt_src),
    .i_rx_data_waiting(i_rx_data_waiting), .i_phys_resp_busy(i_phys_resp_busy),
    .i_tardy_ack_sent(i_tardy_ack_sent), .i_line_layer_byte_arrived(i_line_layer_byte_arrived),
    .i_line_layer_byte(i_line_layer_byte), .i_cs_tx_start(i_cs_tx_start),
    .i_subaction_gap_end(i_subaction_gap_end), .i_subunit_halt(i_subunit_halt),
    .i_rx_cs_valid(i_rx_cs_valid), .i_rx_seconds_field(i_rx_seconds_field),
    .i_rx_period_count_field(i_rx_period_count_field), .i_seconds_field(i_seconds_field),
    .i_period_count_field(i_period_count_field), .i_rx_ctx_events(i_rx_ctx_events),
    .i_rx_ctx_mask(i_rx_ctx_mask), .i_tx_ctx_events(i_tx_ctx_events),
    .i_tx_ctx_mask(i_tx_ctx_mask)
  );

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge i_clk);
    n_errors++;
    $display("wrong value at %0t ns: run timed out", $time);
    end_sim();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    wr(hlier_pkg::MASK_SET_OFS, ALL);
    rd(ES, d);
    `CHK(d & 32'h9000_FC00, 32'h0000_0000)
    `CHK(o_irq, 1'b0)
    tdone("reset");
    wr(ES, 32'hBFFC_FFFF);
    rdchk(ES, 32'h2FFC_833F);
    `CHK(o_irq, 1'b1)
    wr(EC, 32'h0000_0000);
    rdchk(EC, 32'h2FFC_833F);
    wr(EC, ALL);
    rdchk(ES, 32'h0000_0000);
    `CHK(o_irq, 1'b0)
    tdone("set and clear");
    wr(hlier_pkg::MASK_CLR_OFS, 32'h2000_0000);
    wr(ES, 32'h2000_0000);
    rdchk(ES, 32'h0000_0000);
    `CHK(o_irq, 1'b0)
    wr(hlier_pkg::MASK_SET_OFS, 32'h2000_0000);
    rdchk(ES, 32'h2000_0000);
    `CHK(o_irq, 1'b1)
    wr(EC, ALL);
    rdchk(8'hF8, 32'h0000_0000);
    tdone("mask");
    wr(ES, 32'h0001_0000);
    @(posedge i_clk);
    i_evt_src[17] <= 1'b1;
    cyc(2);
    rd(ES, d);
    `CHK(d & 32'h0003_0000, 32'h0002_0000)
    @(posedge i_clk);
    i_evt_src <= 32'h0000_0000;
    wr(EC, ALL);
    @(posedge i_clk);
    i_addr <= EC;
    i_wdata <= 32'h0000_0001;
    i_wr <= 1'b1;
    i_evt_src[0] <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    cyc(2);
    rdchk(ES, 32'h0000_0001);
    wr(EC, ALL);
    tdone("edges");
    @(posedge i_clk);
    i_subunit_halt <= 4'h1;
    i_evt_src <= 32'h0000_0000;
    @(posedge i_clk);
    i_evt_src[0] <= 1'b1;
    cyc(2);
    rdchk(ES, 32'h0100_0000);
    @(posedge i_clk);
    i_subunit_halt <= 4'h0;
    i_evt_src <= 32'h0000_0000;
    wr(EC, ALL);
    tdone("halt");
    @(posedge i_clk);
    i_rx_data_waiting <= 1'b1;
    cyc(3);
    rdchk(ES, 32'h0000_0000);
    @(posedge i_clk);
    i_rx_data_waiting <= 1'b0;
    wr(hlier_pkg::HOST_CTRL_SET_OFS, 32'h2000_0000);
    `CHK(o_late_ack_report_enable, 1'b1)
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      {i_rx_data_waiting, i_phys_resp_busy, i_tardy_ack_sent} <= 3'b001 << k;
      cyc(2);
      rdchk(ES, 32'h0800_0000);
      @(posedge i_clk);
      {i_rx_data_waiting, i_phys_resp_busy, i_tardy_ack_sent} <= 3'b000;
      wr(EC, ALL);
    end
    wr(hlier_pkg::HOST_CTRL_CLR_OFS, 32'h2000_0000);
    tdone("late ack");
    @(posedge i_clk);
    i_line_layer_byte_arrived <= 1'b1;
    i_line_layer_byte <= 8'hA5;
    @(posedge i_clk);
    i_line_layer_byte_arrived <= 1'b0;
    cyc(2);
    rdchk(ES, 32'h0400_0000);
    rdchk(hlier_pkg::LINE_CTRL_OFS, 32'h00A5_0000);
    wr(EC, ALL);
    tdone("line byte");
    wr(hlier_pkg::LINK_CTRL_SET_OFS, 32'h0020_0000);
    `CHK(o_timing_root_enable, 1'b1)
    @(posedge i_clk);
    i_cs_tx_start <= 1'b1;
    @(posedge i_clk);
    i_cs_tx_start <= 1'b0;
    cyc(5);
    i_subaction_gap_end <= 1'b1;
    @(posedge i_clk);
    i_subaction_gap_end <= 1'b0;
    cyc(30);
    rdchk(ES, 32'h0000_0000);
    `CHK(o_timing_root_enable, 1'b1)
    @(posedge i_clk);
    i_cs_tx_start <= 1'b1;
    @(posedge i_clk);
    i_cs_tx_start <= 1'b0;
    for (n = 1; n < 40; n++) begin
      @(posedge i_clk);
      #1;
      if (o_timing_root_enable !== 1'b1) break;
    end
    `CHK(n >= 19 && n <= 24, 1'b1)
    rdchk(ES, 32'h0200_0000);
    wr(EC, ALL);
    tdone("overlong");
    @(posedge i_clk);
    i_seconds_field <= 7'h11;
    i_rx_seconds_field <= 7'h11;
    i_period_count_field <= 13'h0123;
    i_rx_period_count_field <= 13'h0123;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_rx_cs_valid <= 1'b1;
      @(posedge i_clk);
      i_rx_cs_valid <= 1'b0;
      i_rx_period_count_field <= 13'h0124;
      cyc(2);
      rdchk(ES, k ? 32'h0080_0000 : 32'h0000_0000);
    end
    wr(EC, ALL);
    tdone("timer");
    @(posedge i_clk);
    i_rx_ctx_events <= 8'h04;
    i_rx_ctx_mask <= 8'h04;
    i_tx_ctx_events <= 8'h10;
    cyc(3);
    rdchk(ES, 32'h0000_0080);
    @(posedge i_clk);
    i_rx_ctx_events <= 8'h00;
    i_tx_ctx_mask <= 8'h10;
    cyc(3);
    rdchk(ES, 32'h0000_0040);
    tdone("summaries");
    end_sim();
  end
endmodule
